// ---- logic/cbu_pkg.sv ----
// Purpose: Shared constants and types for the conditional branch unit
// Assumes: 16-bit address bus, 8-bit data bus, single CPU clock
// Notes: Opcodes and the dummy-read address are fixed by the instruction set
package cbu_pkg;
    // Bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // Branch opcodes
    localparam logic [7:0] OP_ALWAYS = 8'h20;
    localparam logic [7:0] OP_NEVER = 8'h21;
    localparam logic [7:0] OP_UHI = 8'h22;
    localparam logic [7:0] OP_ULS = 8'h23;
    localparam logic [7:0] OP_UHS = 8'h24;
    localparam logic [7:0] OP_ULO = 8'h25;
    localparam logic [7:0] OP_NE = 8'h26;
    localparam logic [7:0] OP_EQ = 8'h27;
    localparam logic [7:0] OP_VC = 8'h28;
    localparam logic [7:0] OP_VS = 8'h29;
    localparam logic [7:0] OP_PL = 8'h2A;
    localparam logic [7:0] OP_MI = 8'h2B;
    localparam logic [7:0] OP_SGE = 8'h2C;
    localparam logic [7:0] OP_SLT = 8'h2D;
    localparam logic [7:0] OP_SGT = 8'h2E;
    localparam logic [7:0] OP_SLE = 8'h2F;
    // Opcode family mask: relative branches are 0x20..0x2F
    localparam logic [3:0] OP_FAMILY = 4'h2;
    // Low bit of the opcode family field
    localparam int FAM_LSB = 4;
    // Dummy third-cycle address and next-instruction step
    localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
    localparam logic [15:0] PC_STEP = 16'h0002;
    localparam logic [15:0] ADDR_ONE = 16'h0001;
    localparam logic [15:0] RESET_PC = 16'h0000;
    // Condition flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_W = 8;
    // Sequencer states
    typedef enum logic [1:0] {
        CBU_ST_FETCH = 2'b00,
        CBU_ST_OFFSET = 2'b01,
        CBU_ST_DUMMY = 2'b10
    } cbu_state_t;
    // Processor bus request
    typedef struct packed {
        logic [15:0] addr;
        logic rd_wr;
        logic valid;
    } cbu_bus_t;
endpackage : cbu_pkg

// ---- logic/cbu_branch_unit.sv ----
// Purpose: Executes relative conditional branches over a 3-cycle read sequence
// Assumes: Memory returns read data in the same cycle the address is shown
// Notes: Non-branch opcodes are flagged and skipped by one byte
// Notes: Flags are read in the dummy cycle, so late flag updates count
// Notes: Reset starts fetching at the reset address; no vector fetch
// Behaviour
// [RULE1] Negative branch taken only when N set
// [RULE2] Nonzero branches on Z clear; equal on Z
// [RULE3] Taken target is opcode address plus two plus offset
// [RULE4] Three reads: opcode, offset, dummy FFFF
// [RULE5] Signed greater/less-equal use Z or (N xor V)
// [RULE6] Signed greater-equal/less use N xor V
// [RULE7] Unsigned higher/lower-same use C or Z
// [RULE8] Unsigned higher-same/lower use carry flag
// [RULE9] Overflow, no-overflow, positive test V and N
// [RULE10] Always jumps; never skips but eats offset
// [RULE11] Offset byte sign-extended before the add
// [RULE12] Branches never alter condition flags
// [RULE13] Untaken branch continues at opcode plus two
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit
    import cbu_pkg::*;
#(
    parameter int AW = 16 // Address width
) (
    input wire logic clk_i, // 20 MHz CPU clock
    input wire logic rst_b_i, // Async reset, active low
    input wire logic [7:0] rdata_i, // Read data from program memory
    input wire logic [cbu_pkg::FLG_W-1:0] flags_i, // Condition flags in
    output var cbu_pkg::cbu_bus_t bus_o, // Address, read strobe, valid
    output logic [cbu_pkg::FLG_W-1:0] flags_o, // Condition flags out
    output logic [15:0] pc_o, // Program counter
    output logic taken_o, // Pulse: branch taken
    output logic done_o, // Pulse: instruction finished
    output logic illegal_o // Pulse: opcode not a branch
);
    import cbu_pkg::*;

    // Width check at elaboration; the bus struct carries a fixed-width address
    if (AW != ADDR_W) begin : g_bad_aw
        $error("cbu_branch_unit: AW must equal ADDR_W");
    end

    cbu_state_t state_ff; // Sequencer state
    cbu_state_t nxt_state; // Next sequencer state
    logic [15:0] pc_ff; // Opcode address of current instruction
    logic [15:0] nxt_pc; // Next opcode address
    logic [7:0] op_ff; // Latched opcode
    logic [7:0] off_ff; // Latched offset byte
    cbu_bus_t bus_ff; // Registered bus request
    cbu_bus_t nxt_bus; // Next bus request
    logic [FLG_W-1:0] flags_ff; // Registered flags
    logic taken_ff; // Taken pulse
    logic done_ff; // Done pulse
    logic illegal_ff; // Illegal pulse
    logic cond; // Branch condition of latched opcode
    logic [15:0] off_ext; // Sign-extended offset
    logic n_x_v; // N xor V
    logic fam_hit; // Fetched byte lies in the branch family

    // Condition decode from latched opcode and live flags
    always_comb begin
        n_x_v = flags_i[FLG_N] ^ flags_i[FLG_V]; // RULE6
        case (op_ff)
            // Unconditional pair
            OP_ALWAYS: cond = 1'b1; // RULE10
            OP_NEVER: cond = 1'b0; // RULE10
            // Unsigned compares
            OP_UHI: cond = ~(flags_i[FLG_C] | flags_i[FLG_Z]); // RULE7
            OP_ULS: cond = flags_i[FLG_C] | flags_i[FLG_Z]; // RULE7
            OP_UHS: cond = ~flags_i[FLG_C]; // RULE8
            OP_ULO: cond = flags_i[FLG_C]; // RULE8
            // Zero flag tests
            OP_NE: cond = ~flags_i[FLG_Z]; // RULE2
            OP_EQ: cond = flags_i[FLG_Z]; // RULE2
            // Overflow and sign tests
            OP_VC: cond = ~flags_i[FLG_V]; // RULE9
            OP_VS: cond = flags_i[FLG_V]; // RULE9
            OP_PL: cond = ~flags_i[FLG_N]; // RULE9
            OP_MI: cond = flags_i[FLG_N]; // RULE1
            // Signed compares
            OP_SGE: cond = ~n_x_v; // RULE6
            OP_SLT: cond = n_x_v; // RULE6
            OP_SGT: cond = ~(flags_i[FLG_Z] | n_x_v); // RULE5
            OP_SLE: cond = flags_i[FLG_Z] | n_x_v; // RULE5
            default: cond = 1'b0; // Not a branch
        endcase
    end

    // Offset sign extension; the top data bit fills the high address byte
    always_comb begin
        off_ext = {{(ADDR_W - DATA_W){off_ff[DATA_W-1]}}, off_ff}; // RULE11
    end

    // Family decode of the byte on the data bus; anything else is not ours
    always_comb begin
        fam_hit = (rdata_i[DATA_W-1:FAM_LSB] == OP_FAMILY); // RULE4
    end

    // Next state, bus request and PC
    always_comb begin
        // Defaults: hold state, pc and bus request
        nxt_state = state_ff;
        nxt_pc = pc_ff;
        nxt_bus = bus_ff;
        case (state_ff)
            CBU_ST_FETCH: begin
                // Opcode read at pc presented now; capture into op_ff
                if (fam_hit) begin
                    // Relative branch: offset byte is read next
                    nxt_state = CBU_ST_OFFSET;
                    nxt_bus.addr = pc_ff + ADDR_ONE; // RULE4
                end else begin
                    // Not a branch: step over the single byte
                    nxt_pc = pc_ff + ADDR_ONE;
                    nxt_bus.addr = pc_ff + ADDR_ONE;
                end
            end
            CBU_ST_OFFSET: begin
                // Offset byte on the bus now; dummy read follows
                nxt_state = CBU_ST_DUMMY;
                nxt_bus.addr = DUMMY_ADDR; // RULE4
            end
            CBU_ST_DUMMY: begin
                // Dummy read at FFFF now; decide and fetch the next opcode
                nxt_state = CBU_ST_FETCH;
                if (cond) begin
                    // Taken: relative to the end of the two-byte instruction
                    nxt_pc = pc_ff + PC_STEP + off_ext; // RULE3
                end else begin
                    // Not taken: fall through, same three cycles spent
                    nxt_pc = pc_ff + PC_STEP; // RULE13
                end
                nxt_bus.addr = nxt_pc;
            end
            default: begin
                // Unused state code: recover to fetch
                nxt_state = CBU_ST_FETCH;
                nxt_bus.addr = pc_ff;
            end
        endcase
        // Every cycle of the sequence is a read
        nxt_bus.rd_wr = 1'b1; // RULE4
        nxt_bus.valid = 1'b1;
    end

    // State, PC and bus registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_ff <= CBU_ST_FETCH;
            pc_ff <= RESET_PC;
            bus_ff <= '{addr: RESET_PC, rd_wr: 1'b1, valid: 1'b1};
        end else begin
            state_ff <= nxt_state;
            pc_ff <= nxt_pc;
            bus_ff <= nxt_bus;
        end
    end

    // Opcode capture during the fetch cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            op_ff <= '0;
        end else if (state_ff == CBU_ST_FETCH) begin
            // Held through offset and dummy cycles for the decode
            op_ff <= rdata_i;
        end
    end

    // Offset capture; done even when the branch can never be taken
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            off_ff <= '0;
        end else if (state_ff == CBU_ST_OFFSET) begin
            off_ff <= rdata_i; // RULE10
        end
    end

    // Flags pass through untouched
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= flags_i; // RULE12
        end
    end

    // Taken pulse: one cycle after a dummy read whose condition held
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            taken_ff <= 1'b0;
        end else begin
            taken_ff <= (state_ff == CBU_ST_DUMMY) && cond;
        end
    end

    // Done pulse: one cycle after every dummy read
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == CBU_ST_DUMMY); // RULE4
        end
    end

    // Illegal pulse: fetched byte outside the branch family
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            illegal_ff <= 1'b0;
        end else begin
            illegal_ff <= (state_ff == CBU_ST_FETCH) && !fam_hit;
        end
    end

    // Every output straight from its register
    assign bus_o = bus_ff;
    assign flags_o = flags_ff;
    assign pc_o = pc_ff;
    assign taken_o = taken_ff;
    assign done_o = done_ff;
    assign illegal_o = illegal_ff;
endmodule : cbu_branch_unit
`default_nettype wire

// ---- dv/cbu_monitor.sv ----
// Purpose: Port checks on the conditional branch unit
// Assumes: One clock, async active-low reset
// Notes: Bound to every instance of the unit
`timescale 1ns/1ps
`default_nettype none
module cbu_monitor
    import cbu_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_b_i, // Reset
    input wire logic [7:0] rdata_i, // Read data
    input wire logic [cbu_pkg::FLG_W-1:0] flags_i, // Flags in
    input wire cbu_pkg::cbu_bus_t bus_o, // Bus request
    input wire logic [cbu_pkg::FLG_W-1:0] flags_o, // Flags out
    input wire logic [15:0] pc_o, // Opcode address
    input wire logic taken_o, // Taken pulse
    input wire logic done_o, // Done pulse
    input wire logic illegal_o // Illegal pulse
);
    wire logic [15:0] off_x = {{8{rdata_i[7]}}, rdata_i}; // Offset, sign-extended
    // Decision per opcode; odd opcodes take the listed term
    function automatic logic want(input logic [7:0] op, input logic [7:0] f);
        logic [7:0] odd;
        odd = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
        return odd[op[3:1]] ^ ~op[0];
    endfunction : want
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_read_only: assert property (bus_o.rd_wr && bus_o.valid)
        else $error("bus cycle not a read");
    a_opcode_fetch: assert property (done_o |-> $past(bus_o.addr, 3) == $past(pc_o, 3))
        else $error("opcode not read at pc");
    a_offset_fetch: assert property (done_o |-> $past(bus_o.addr, 2) == $past(pc_o, 2) + 16'h0001)
        else $error("offset not read at pc plus one");
    a_dummy_read: assert property (done_o |-> $past(bus_o.addr) == 16'hFFFF)
        else $error("third cycle not at FFFF");
    a_taken_target: assert property (taken_o |-> pc_o == $past(pc_o, 2) + 16'h0002 + $past(off_x, 2))
        else $error("taken target wrong");
    a_untaken_next: assert property (done_o && !taken_o |-> pc_o == $past(pc_o, 2) + 16'h0002)
        else $error("untaken next address wrong");
    a_branch_cond: assert property (done_o |-> taken_o == want($past(rdata_i, 3), $past(flags_i)))
        else $error("branch decision wrong");
    a_flags_kept: assert property (1'b1 |=> flags_o == $past(flags_i))
        else $error("flags altered");
    a_next_fetch: assert property (done_o |-> bus_o.addr == pc_o)
        else $error("next fetch not at new pc");
    a_done_spacing: assert property (done_o |=> !done_o ##1 !done_o)
        else $error("branch shorter than three cycles");
    a_skip_one: assert property (illegal_o |-> pc_o == $past(pc_o) + 16'h0001 && !done_o)
        else $error("non-branch byte not skipped");
    c_back_to_back: cover property (done_o ##3 done_o);
    c_taken: cover property (taken_o);
    c_untaken: cover property (done_o && !taken_o);
    c_illegal: cover property (illegal_o);
endmodule : cbu_monitor
bind cbu_branch_unit cbu_monitor mon (.clk_i, .rst_b_i, .rdata_i, .flags_i, .bus_o, .flags_o,
    .pc_o, .taken_o, .done_o, .illegal_o);
`default_nettype wire

// ---- dv/cbu_mem_model.sv ----
// Purpose: Program memory on the processor bus
// Assumes: Data valid in the cycle the address shows
// Notes: Empty cells give a pattern that flips each cycle
`timescale 1ns/1ps
`default_nettype none
module cbu_mem_model
    import cbu_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire cbu_pkg::cbu_bus_t bus_i, // Bus request
    output logic [7:0] rdata_o // Read data
);
    logic [7:0] mem [0:65535]; // Program bytes
    bit ld [0:65535]; // Byte has been loaded
    logic [7:0] junk_ff = 8'hA5; // Stale-free filler
    // Flip filler so no old byte looks valid
    always @(posedge clk_i) junk_ff <= ~junk_ff;
    // Same-cycle read; a load shows on the bus at once
    assign rdata_o = (bus_i.valid && bus_i.rd_wr && ld[bus_i.addr]) ?
        mem[bus_i.addr] : junk_ff;
    // Place one program byte
    task automatic load(input logic [15:0] a, input logic [7:0] d);
        mem[a] = d;
        ld[a] = 1'b1;
    endtask : load
endmodule : cbu_mem_model
`default_nettype wire

// ---- dv/cbu_branch_unit_tb.sv ----
// Purpose: Self-checking bench for the branch unit
// Assumes: 20 MHz clock, memory answers same cycle
// Notes: Every opcode meets every flag nibble
`timescale 1ns/1ps
`default_nettype none
module cbu_branch_unit_tb;
    import cbu_pkg::*;
    logic clk_i = 1'b0; // Clock
    logic rst_b_i = 1'b0; // Reset
    logic [7:0] flags_i = 8'h00; // Flags
    logic [7:0] rdata; // Memory data
    cbu_bus_t bus; // Bus request
    logic [7:0] flags_o; // Flags out
    logic [15:0] pc_o; // Opcode address
    logic taken_o, done_o, illegal_o; // Pulses
    logic [15:0] exp_pc = 16'h0000; // Expected pc
    logic [7:0] offs [4] = '{8'h7F, 8'hF0, 8'h05, 8'h80}; // Offsets, both signs
    int num_errors = 0; // Mismatches
    int cmp_count = 0; // Compares
    always #25 clk_i = ~clk_i;
    cbu_branch_unit uut (.clk_i, .rst_b_i, .rdata_i(rdata), .flags_i, .bus_o(bus), .flags_o,
        .pc_o, .taken_o, .done_o, .illegal_o);
    cbu_mem_model pmem (.clk_i, .bus_i(bus), .rdata_o(rdata));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : close_out
    // One branch over its three bus cycles
    task automatic run_br(input logic [7:0] op, input logic [7:0] off, input logic [7:0] f);
        logic [7:0] odd;
        logic t;
        logic [15:0] nx;
        pmem.load(exp_pc, op);
        pmem.load(exp_pc + 16'h0001, off);
        odd = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
        t = odd[op[3:1]] ^ ~op[0];
        nx = exp_pc + 16'h0002 + (t ? {{8{off[7]}}, off} : 16'h0000);
        @(posedge clk_i);
        flags_i <= f;
        @(posedge clk_i);
        #1 check(bus.addr, 16'hFFFF);
        @(posedge clk_i);
        #1 check(16'(taken_o), 16'(t));
        check(16'(done_o), 16'h0001);
        check(pc_o, nx);
        check(16'(flags_o), 16'(f));
        check(16'(illegal_o), 16'h0000);
        exp_pc = nx;
    endtask : run_br
    // One byte outside the branch family: flagged and stepped over
    task automatic run_skip(input logic [7:0] op);
        pmem.load(exp_pc, op);
        @(posedge clk_i);
        #1 check(16'(illegal_o), 16'h0001);
        check(16'(done_o), 16'h0000);
        check(pc_o, exp_pc + 16'h0001);
        check(bus.addr, exp_pc + 16'h0001);
        exp_pc = exp_pc + 16'h0001;
    endtask : run_skip
    initial begin
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        run_skip(8'h1F);
        run_skip(8'h30);
        for (int i = 0; i < 256; i++) run_br({4'h2, i[3:0]}, offs[i[1:0]], {~i[7:4], i[7:4]});
        close_out();
    end
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule : cbu_branch_unit_tb
`default_nettype wire
